// >>> rtl/spr_pkg.sv
`default_nettype none
package spr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int LVL_W  = 4;

  // Offsets inside the shared serial block's window
  localparam logic [ADDR_W-1:0] OFF_SETUP   = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_TIMING  = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_FLAGS   = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_ARM     = 12'h40c;
  localparam logic [ADDR_W-1:0] OFF_DISARM  = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_SCALER  = 12'h424;
  localparam logic [ADDR_W-1:0] OFF_PEND    = 12'h428;
  localparam logic [ADDR_W-1:0] OFF_QSETUP  = 12'he00;
  localparam logic [ADDR_W-1:0] OFF_QCOND   = 12'he04;
  localparam logic [ADDR_W-1:0] OFF_QTHR    = 12'he08;
  localparam logic [ADDR_W-1:0] OFF_QARM    = 12'he10;
  localparam logic [ADDR_W-1:0] OFF_QDISARM = 12'he14;
  localparam logic [ADDR_W-1:0] OFF_QPEND   = 12'he18;
  localparam logic [ADDR_W-1:0] OFF_PUSH    = 12'he20;
  localparam logic [ADDR_W-1:0] OFF_POP     = 12'he30;
  localparam logic [ADDR_W-1:0] OFF_PEEK    = 12'he40;
  localparam logic [ADDR_W-1:0] OFF_SIG     = 12'hffc;

  // Implemented bits and reset values
  localparam logic [DATA_W-1:0] SETUP_IMPL  = 32'h0000_0fbd;
  localparam logic [DATA_W-1:0] SETUP_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TIMING_IMPL = 32'h0000_ffff;
  localparam logic [DATA_W-1:0] SCALER_IMPL = 32'h0000_ffff;
  localparam logic [DATA_W-1:0] FLAGS_RST   = 32'h0000_0100;
  localparam logic [DATA_W-1:0] QCOND_RST   = 32'h0000_0030;
  localparam logic [DATA_W-1:0] QTHR_IMPL   = 32'h000f_0f03;
  localparam logic [8:0]        SPI_IRQ_IMPL = 9'h120;

  // Field positions
  localparam int SET_EN     = 0;
  localparam int FL_DONE    = 5;
  localparam int FL_IDLE    = 8;
  localparam int QS_TXON    = 0;
  localparam int QS_RXON    = 1;
  localparam int QS_TXFLUSH = 16;
  localparam int QS_RXFLUSH = 17;
  localparam int QC_TXERR   = 0;
  localparam int QC_RXERR   = 1;
  localparam int QC_PERINT  = 3;
  localparam int QC_TXEMPTY = 4;
  localparam int QC_TXNFULL = 5;
  localparam int QC_RXNEMPT = 6;
  localparam int QC_RXFULL  = 7;
  localparam int QC_TXLVL   = 8;
  localparam int QC_RXLVL   = 16;
  localparam int QT_TXENA   = 0;
  localparam int QT_RXENA   = 1;
  localparam int QT_TXLVL   = 8;
  localparam int QT_RXLVL   = 16;
  localparam int QI_TXERR   = 0;
  localparam int QI_RXERR   = 1;
  localparam int QI_TXLVL   = 2;
  localparam int QI_RXLVL   = 3;
endpackage
`default_nettype wire

// >>> rtl/spr_queue_mem.sv
`timescale 1ns/100ps
`default_nettype none
module spr_queue_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } spr_mem_state_t;

  spr_mem_state_t m_q;
  spr_mem_state_t m_d;

  // Same-cycle write to the read address is passed straight through
  always_comb begin
    m_d = m_q;
    if (we) begin
      m_d.mem[waddr] = wdata;
    end
    m_d.rdata = (we && (waddr == raddr)) ? wdata : m_q.mem[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rdata = m_q.rdata;
endmodule
`default_nettype wire

// >>> rtl/spr_regbank.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (R1) Offsets decode from the low address bits, relative to the shared window base.
// (R2) Reset values cover implemented bits; reserved bits read zero.
// (R3) Transfer flags at 0x408 reset to 0x100; done flag clears on write one.
// (R4) Arm register reads the full mask; writing ones sets mask bits.
// (R5) Disarm register is write-only; writing ones clears mask bits.
// (R6) Peek port returns receive queue head without popping it.
// (R7) Threshold register levels decide when queue level interrupts are raised.
// (R8) Queue setup holds transmit and receive queue enables; resets to zero.
// (R9) Signature register is read-only and also drives the shared identification output.
// (R10) Queue condition register resets to 0x30.
// (R11) Setup enable clear holds the engine disabled and idle.
// (R12) Software disables queues, programs setup, re-enables queues, then sets enable.
// (R13) Each pending interrupt bit is its condition ANDed with its arm bit.
module spr_regbank #(
  parameter int          DEPTH     = 8,
  parameter logic [31:0] SIGNATURE = 32'h0000_5a01  // Arbitrary value
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [spr_pkg::DATA_W-1:0] pwdata,
  output var  logic [spr_pkg::DATA_W-1:0] prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  output var  logic                      tx_valid,
  output var  logic [spr_pkg::DATA_W-1:0] tx_data,
  input  wire logic                      tx_ready,
  input  wire logic                      rx_valid,
  input  wire logic [spr_pkg::DATA_W-1:0] rx_data,
  output var  logic                      rx_ready,
  input  wire logic                      xfer_done,
  input  wire logic                      engine_busy,
  output var  logic                      engine_enable,
  output var  logic [11:0]               cfg_setup,
  output var  logic [15:0]               cfg_timing,
  output var  logic [15:0]               cfg_scaler,
  output var  logic [spr_pkg::DATA_W-1:0] sig_for_shared_id,
  output var  logic                      irq
);
  import spr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [11:0]   setup;
    logic [15:0]   timing;
    logic [15:0]   scaler;
    logic          done;
    logic          idle;
    logic [8:0]    arm;
    logic          tx_on;
    logic          rx_on;
    logic [19:0]   thr;
    logic          txerr;
    logic          rxerr;
    logic [3:0]    qarm;
    logic [AW-1:0] th;
    logic [AW-1:0] tt;
    logic [CW-1:0] tc;
    logic [AW-1:0] rh;
    logic [AW-1:0] rt;
    logic [CW-1:0] rc;
    logic [31:0]   rdata;
    logic          slverr;
  } spr_state_t;

  localparam spr_state_t ST_RST = '{idle: FLAGS_RST[FL_IDLE], default: '0};

  spr_state_t        s_q;
  spr_state_t        s_d;
  logic [ADDR_W-1:0] off;
  logic              setup_ph;
  logic              wr_acc;
  logic              rd_acc;
  logic              tx_full;
  logic              rx_full;
  logic              push;
  logic              pop;
  logic              tx_take;
  logic              rx_put;
  logic              tx_ovf;
  logic              rx_ovf;
  logic [8:0]        spi_flags;
  logic [8:0]        spi_pend;
  logic [3:0]        qraw;
  logic [3:0]        qpend;
  logic [31:0]       qcond;
  logic [31:0]       rdv;
  logic              hit;
  logic              done_clr;
  logic              txerr_clr;
  logic              rxerr_clr;
  logic [31:0]       tx_rdata;
  logic [31:0]       rx_rdata;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic is_wr(input logic acc, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return acc && (a == o);
  endfunction

  assign off      = paddr[ADDR_W-1:0];  // R1
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign tx_full  = (s_q.tc == CW'(DEPTH));
  assign rx_full  = (s_q.rc == CW'(DEPTH));

  assign engine_enable = s_q.setup[SET_EN];
  assign tx_valid      = engine_enable & s_q.tx_on & (s_q.tc != '0);  // R11
  assign rx_ready      = engine_enable & s_q.rx_on & ~rx_full;        // R11
  assign tx_take       = tx_valid & tx_ready;
  assign rx_put        = rx_valid & rx_ready;
  assign rx_ovf        = rx_valid & engine_enable & s_q.rx_on & rx_full;
  assign push          = is_wr(wr_acc, off, OFF_PUSH) & s_q.tx_on & ~tx_full;
  assign tx_ovf        = is_wr(wr_acc, off, OFF_PUSH) & tx_full;
  assign pop           = is_wr(rd_acc, off, OFF_POP) & (s_q.rc != '0);

  always_comb begin
    s_d = s_q;
    spi_flags = '0;
    spi_flags[FL_DONE] = s_q.done;
    spi_flags[FL_IDLE] = s_q.idle;
    spi_pend = spi_flags & s_q.arm;  // R13
    qraw = '0;
    qraw[QI_TXERR] = s_q.txerr;
    qraw[QI_RXERR] = s_q.rxerr;
    qraw[QI_TXLVL] = s_q.thr[QT_TXENA] && (32'(s_q.tc) <= 32'(s_q.thr[QT_TXLVL +: LVL_W]));  // R7
    qraw[QI_RXLVL] = s_q.thr[QT_RXENA] && (32'(s_q.rc) > 32'(s_q.thr[QT_RXLVL +: LVL_W]));   // R7
    qpend = qraw & s_q.qarm;  // R13
    qcond = '0;  // R10
    qcond[QC_TXERR]   = s_q.txerr;
    qcond[QC_RXERR]   = s_q.rxerr;
    qcond[QC_PERINT]  = |spi_pend;
    qcond[QC_TXEMPTY] = (s_q.tc == '0);
    qcond[QC_TXNFULL] = ~tx_full;
    qcond[QC_RXNEMPT] = (s_q.rc != '0);
    qcond[QC_RXFULL]  = rx_full;
    qcond[QC_TXLVL +: 5] = 5'(s_q.tc);
    qcond[QC_RXLVL +: 5] = 5'(s_q.rc);

    rdv = '0;  // R2
    hit = 1'b1;
    case (off)
      OFF_SETUP:   rdv = 32'(s_q.setup);
      OFF_TIMING:  rdv = 32'(s_q.timing);
      OFF_FLAGS:   rdv = 32'(spi_flags);
      OFF_ARM:     rdv = 32'(s_q.arm);  // R4
      OFF_DISARM:  rdv = '0;            // R5
      OFF_SCALER:  rdv = 32'(s_q.scaler);
      OFF_PEND:    rdv = 32'(spi_pend);
      OFF_QSETUP: begin
        rdv[QS_TXON] = s_q.tx_on;
        rdv[QS_RXON] = s_q.rx_on;
      end
      OFF_QCOND:   rdv = qcond;
      OFF_QTHR:    rdv = 32'(s_q.thr);
      OFF_QARM:    rdv = 32'(s_q.qarm);
      OFF_QDISARM: rdv = 32'(s_q.qarm);
      OFF_QPEND:   rdv = 32'(qpend);
      OFF_PUSH:    rdv = '0;
      OFF_POP:     rdv = rx_rdata;
      OFF_PEEK:    rdv = rx_rdata;   // R6
      OFF_SIG:     rdv = SIGNATURE;  // R9
      default:     hit = 1'b0;
    endcase
    // Read data is captured in the setup phase and shown in the access phase
    if (setup_ph) begin
      s_d.rdata  = rdv;
      s_d.slverr = ~hit;
    end

    if (wr_acc) begin
      case (off)
        OFF_SETUP:   s_d.setup  = 12'(pwdata & SETUP_IMPL);
        OFF_TIMING:  s_d.timing = 16'(pwdata & TIMING_IMPL);
        OFF_SCALER:  s_d.scaler = 16'(pwdata & SCALER_IMPL);
        OFF_ARM:     s_d.arm    = s_q.arm | (9'(pwdata) & SPI_IRQ_IMPL);  // R4
        OFF_DISARM:  s_d.arm    = s_q.arm & ~9'(pwdata);                 // R5
        OFF_QSETUP: begin
          s_d.tx_on = pwdata[QS_TXON];  // R8
          s_d.rx_on = pwdata[QS_RXON];  // R8
        end
        OFF_QTHR:    s_d.thr  = 20'(pwdata & QTHR_IMPL);  // R7
        OFF_QARM:    s_d.qarm = s_q.qarm | 4'(pwdata);
        OFF_QDISARM: s_d.qarm = s_q.qarm & ~4'(pwdata);
        default: ;
      endcase
    end

    // Sticky flags: a read or a written one clears them, a new event wins
    done_clr  = is_wr(rd_acc, off, OFF_FLAGS) | (is_wr(wr_acc, off, OFF_FLAGS) & pwdata[FL_DONE]);
    txerr_clr = is_wr(rd_acc, off, OFF_QCOND) | (is_wr(wr_acc, off, OFF_QCOND) & pwdata[QC_TXERR]);
    rxerr_clr = is_wr(rd_acc, off, OFF_QCOND) | (is_wr(wr_acc, off, OFF_QCOND) & pwdata[QC_RXERR]);
    s_d.done  = xfer_done | (s_q.done & ~done_clr);  // R3
    s_d.txerr = tx_ovf | (s_q.txerr & ~txerr_clr);
    s_d.rxerr = rx_ovf | (s_q.rxerr & ~rxerr_clr);
    s_d.idle  = ~engine_busy;

    if (push) begin
      s_d.tt = nxt(s_q.tt);
    end
    if (tx_take) begin
      s_d.th = nxt(s_q.th);
    end
    s_d.tc = s_q.tc + CW'(push) - CW'(tx_take);
    if (rx_put) begin
      s_d.rt = nxt(s_q.rt);
    end
    if (pop) begin
      s_d.rh = nxt(s_q.rh);
    end
    s_d.rc = s_q.rc + CW'(rx_put) - CW'(pop);

    // Flush bits act once and are not stored
    if (is_wr(wr_acc, off, OFF_QSETUP) && pwdata[QS_TXFLUSH]) begin
      s_d.th = '0;
      s_d.tt = '0;
      s_d.tc = '0;
    end
    if (is_wr(wr_acc, off, OFF_QSETUP) && pwdata[QS_RXFLUSH]) begin
      s_d.rh = '0;
      s_d.rt = '0;
      s_d.rc = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= ST_RST;  // R2
    end else begin
      s_q <= s_d;
    end
  end

  spr_queue_mem #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (push),
    .waddr   (s_q.tt),
    .wdata   (pwdata),
    .raddr   (s_d.th),
    .rdata   (tx_rdata)
  );

  spr_queue_mem #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (rx_put),
    .waddr   (s_q.rt),
    .wdata   (rx_data),
    .raddr   (s_d.rh),
    .rdata   (rx_rdata)
  );

  assign pready            = psel & penable;
  assign prdata            = s_q.rdata;
  assign pslverr           = psel & penable & s_q.slverr;
  assign tx_data           = tx_rdata;
  assign cfg_setup         = s_q.setup;
  assign cfg_timing        = s_q.timing;
  assign cfg_scaler        = s_q.scaler;
  assign sig_for_shared_id = SIGNATURE;  // R9
  assign irq               = (|spi_pend) | (|qpend);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_win_decode;
    setup_ph && (off == OFF_SETUP) |=> !s_q.slverr;
  endproperty
  a_win_decode: assert property (p_win_decode)  // R1
    else $error("Setup offset not decoded inside window");

  property p_reserved_zero;
    setup_ph && !pwrite && (off == OFF_SETUP) |=> (prdata & ~SETUP_IMPL) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)  // R2
    else $error("Reserved setup bits read nonzero");

  property p_done_w1c;
    is_wr(wr_acc, off, OFF_FLAGS) && pwdata[FL_DONE] && !xfer_done |=> !s_q.done;
  endproperty
  a_done_w1c: assert property (p_done_w1c)  // R3
    else $error("Done flag not cleared by write one");

  property p_arm_set;
    is_wr(wr_acc, off, OFF_ARM) && pwdata[FL_DONE] |=> s_q.arm[FL_DONE] ##1 $stable(s_q.arm) || wr_acc;
  endproperty
  a_arm_set: assert property (p_arm_set)  // R4
    else $error("Arm write did not set mask bit");

  property p_disarm_clr;
    is_wr(wr_acc, off, OFF_DISARM) && pwdata[FL_IDLE] |=> !s_q.arm[FL_IDLE];
  endproperty
  a_disarm_clr: assert property (p_disarm_clr)  // R5
    else $error("Disarm write did not clear mask bit");

  property p_peek_keeps;
    is_wr(rd_acc, off, OFF_PEEK) && !rx_put |=> s_q.rc == $past(s_q.rc);
  endproperty
  a_peek_keeps: assert property (p_peek_keeps)  // R6
    else $error("Peek changed receive queue count");

  property p_rx_level;
    qpend[QI_RXLVL] |-> s_q.thr[QT_RXENA] && (32'(s_q.rc) > 32'(s_q.thr[QT_RXLVL +: LVL_W])) && irq;
  endproperty
  a_rx_level: assert property (p_rx_level)  // R7
    else $error("Receive level interrupt without threshold cause");

  property p_qsetup_wr;
    is_wr(wr_acc, off, OFF_QSETUP) |=> s_q.tx_on == $past(pwdata[QS_TXON]) && s_q.rx_on == $past(pwdata[QS_RXON]);
  endproperty
  a_qsetup_wr: assert property (p_qsetup_wr)  // R8
    else $error("Queue enables not taken from write");

  property p_sig_read;
    setup_ph && !pwrite && (off == OFF_SIG) |=> prdata == SIGNATURE && !pslverr;
  endproperty
  a_sig_read: assert property (p_sig_read)  // R9
    else $error("Signature read returned wrong value");

  property p_qcond_empty;
    setup_ph && !pwrite && (off == OFF_QCOND) && (s_q.tc == '0) |=> prdata[QC_TXNFULL:QC_TXEMPTY] == 2'b11;
  endproperty
  a_qcond_empty: assert property (p_qcond_empty)  // R10
    else $error("Empty transmit queue not reported");

  property p_disabled_idle;
    !engine_enable |-> !tx_valid && !rx_ready;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)  // R11
    else $error("Engine handshake active while disabled");

  property p_pend_and;
    setup_ph && !pwrite && (off == OFF_PEND) |=> prdata[FL_DONE] == ($past(s_q.done) && $past(s_q.arm[FL_DONE]));
  endproperty
  a_pend_and: assert property (p_pend_and)  // R13
    else $error("Pending bit raised without arm bit");

  c_push_pop: cover property (push ##[1:20] pop);
  c_rx_full: cover property (rx_full && rx_valid);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> tb/spr_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module spr_engine_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        engine_enable,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  output var  logic        tx_ready,
  output var  logic        rx_valid,
  output var  logic [31:0] rx_data,
  input  wire logic        rx_ready,
  output var  logic        xfer_done,
  output var  logic        engine_busy
);
  logic        hold_q;
  logic [31:0] word_q;
  logic [31:0] junk_q;
  // One word in flight; what is sent comes back as received data
  assign tx_ready    = engine_enable & ~hold_q & ~stall;
  assign rx_valid    = hold_q;
  assign engine_busy = hold_q;
  // No stale word shows while nothing is offered
  assign rx_data     = hold_q ? word_q : junk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q    <= 1'b0;
      word_q    <= '0;
      junk_q    <= 32'h5a5a_a5a5;
      xfer_done <= 1'b0;
    end else begin
      junk_q    <= junk_q + 32'h9e37_79b9;
      xfer_done <= 1'b0;
      if (!engine_enable) begin
        hold_q <= 1'b0;
      end else if (hold_q && rx_ready) begin
        hold_q    <= 1'b0;
        xfer_done <= 1'b1;
      end else if (!hold_q && tx_valid && tx_ready) begin
        hold_q <= 1'b1;
        word_q <= tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_spi_register_map.sv
`timescale 1ns/100ps
`default_nettype none
module test_spi_register_map;
  import spr_pkg::*;
  localparam logic [31:0] SIG_VAL = 32'h0000_3c77;  // Arbitrary value
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        stall = 1'b0;
  logic [31:0] prdata, tx_data, rx_data, sig_out, rd_v;
  logic        pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
  logic        xfer_done, engine_busy, engine_enable, irq, err_v;
  logic [11:0] cfg_setup;
  logic [15:0] cfg_timing, cfg_scaler;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] q[$];
  logic [31:0] mdl[4];
  logic [11:0] rw_off[4] = '{OFF_SETUP, OFF_TIMING, OFF_SCALER, OFF_QTHR};
  logic [31:0] rw_msk[4] = '{SETUP_IMPL, TIMING_IMPL, SCALER_IMPL, QTHR_IMPL};
  logic [11:0] rs_off[14] = '{OFF_SETUP, OFF_TIMING, OFF_FLAGS, OFF_ARM, OFF_DISARM, OFF_SCALER, OFF_PEND,
                              OFF_QSETUP, OFF_QCOND, OFF_QTHR, OFF_QARM, OFF_QDISARM, OFF_QPEND, OFF_SIG};
  logic [31:0] rs_val[14] = '{32'h0, 32'h0, FLAGS_RST, 32'h0, 32'h0, 32'h0, 32'h0,
                              32'h0, QCOND_RST, 32'h0, 32'h0, 32'h0, 32'h0, SIG_VAL};

  always #5 pclk = ~pclk;

  spr_regbank #(.DEPTH(8), .SIGNATURE(SIG_VAL)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .xfer_done(xfer_done), .engine_busy(engine_busy), .engine_enable(engine_enable),
    .cfg_setup(cfg_setup), .cfg_timing(cfg_timing), .cfg_scaler(cfg_scaler),
    .sig_for_shared_id(sig_out), .irq(irq));

  spr_engine_model eng_u (
    .pclk(pclk), .presetn(presetn), .engine_enable(engine_enable), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .xfer_done(xfer_done), .engine_busy(engine_busy));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup cycle, then access until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v  = prdata;
    err_v = pslverr;
    if (n >= 20) chk(32'd0, 32'd1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, {20'h0, a}, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, {20'h0, a}, 32'h0);
    chk(rd_v, exp);
  endtask

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(91433));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rs_off[i]) rchk(rs_off[i], rs_val[i]);
    chk(sig_out, SIG_VAL);
    chk({31'd0, irq}, 32'd0);
    test_end("reset");

    for (int k = 0; k < 2; k++) begin
      foreach (rw_off[i]) begin
        mdl[i] = $urandom();
        wr(rw_off[i], mdl[i]);
      end
      foreach (rw_off[i]) begin
        apb(1'b0, {20'h12345, rw_off[i]}, 32'h0);
        chk(rd_v, mdl[i] & rw_msk[i]);
      end
      chk({20'd0, cfg_setup}, mdl[0] & SETUP_IMPL);
      chk({16'd0, cfg_timing}, mdl[1] & TIMING_IMPL);
      chk({16'd0, cfg_scaler}, mdl[2] & SCALER_IMPL);
      chk({31'd0, engine_enable}, {31'd0, mdl[0][SET_EN]});
    end
    wr(OFF_SETUP, 32'h0);
    wr(OFF_QTHR, 32'h0);
    apb(1'b0, 32'h0000_0700, 32'h0);
    chk({31'd0, err_v}, 32'd1);
    wr(OFF_SIG, 32'hffff_ffff);
    rchk(OFF_SIG, SIG_VAL);
    test_end("registers");

    wr(OFF_ARM, 32'hffff_ffff);
    rchk(OFF_ARM, {23'd0, SPI_IRQ_IMPL});
    rchk(OFF_PEND, 32'h100);
    chk({31'd0, irq}, 32'd1);
    wr(OFF_DISARM, 32'h100);
    rchk(OFF_ARM, 32'h20);
    rchk(OFF_DISARM, 32'h0);
    rchk(OFF_PEND, 32'h0);
    chk({31'd0, irq}, 32'd0);
    test_end("interrupt mask");

    stall <= 1'b1;
    wr(OFF_QSETUP, 32'h0);
    wr(OFF_SETUP, 32'h0);
    wr(OFF_QSETUP, 32'h3);
    rchk(OFF_QSETUP, 32'h3);
    wr(OFF_SETUP, 32'h1);
    repeat (3) begin
      q.push_back($urandom());
      wr(OFF_PUSH, q[$]);
    end
    rchk(OFF_QCOND, 32'h0000_0320);
    wr(OFF_SETUP, 32'h0);
    chk({31'd0, tx_valid}, 32'd0);
    chk({31'd0, rx_ready}, 32'd0);
    stall <= 1'b0;
    repeat (10) @(posedge pclk);
    rchk(OFF_QCOND, 32'h0000_0320);
    wr(OFF_SETUP, 32'h1);
    repeat (30) @(posedge pclk);
    chk({31'd0, irq}, 32'd1);
    rchk(OFF_FLAGS, 32'h120);
    chk({31'd0, irq}, 32'd0);
    rchk(OFF_QCOND, 32'h0003_0070);
    rchk(OFF_PEEK, q[0]);
    rchk(OFF_PEEK, q[0]);
    while (q.size() > 0) rchk(OFF_POP, q.pop_front());
    rchk(OFF_QCOND, QCOND_RST);
    test_end("data path");

    stall <= 1'b1;
    repeat (9) wr(OFF_PUSH, $urandom());
    rchk(OFF_QCOND, 32'h0000_0801);
    rchk(OFF_QCOND, 32'h0000_0800);
    wr(OFF_QSETUP, 32'h0001_0003);
    rchk(OFF_QSETUP, 32'h3);
    rchk(OFF_QCOND, QCOND_RST);
    wr(OFF_QTHR, 32'h1);
    wr(OFF_QARM, 32'h4);
    rchk(OFF_QPEND, 32'h4);
    chk({31'd0, irq}, 32'd1);
    wr(OFF_QDISARM, 32'h4);
    rchk(OFF_QARM, 32'h0);
    chk({31'd0, irq}, 32'd0);
    test_end("queue limits");

    // Fill the receive queue, then overrun it with one more word held by the engine
    wr(OFF_QTHR, 32'h0001_0002);
    repeat (8) begin
      q.push_back($urandom());
      wr(OFF_PUSH, q[$]);
    end
    stall <= 1'b0;
    repeat (20) @(posedge pclk);
    q.push_back($urandom());
    wr(OFF_PUSH, q[$]);
    wr(OFF_QARM, 32'ha);
    rchk(OFF_QPEND, 32'ha);
    chk({31'd0, irq}, 32'd1);
    wr(OFF_FLAGS, 32'h20);
    rchk(OFF_FLAGS, 32'h0);
    wr(OFF_QSETUP, 32'h0002_0003);
    repeat (3) @(posedge pclk);
    rchk(OFF_PEEK, q[8]);
    rchk(OFF_QCOND, 32'h0001_007a);
    rchk(OFF_QCOND, 32'h0001_0078);
    test_end("receive limits");
    complete_run();
  end
endmodule
`default_nettype wire
